// ### common/pms_pkg.sv
package pms_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned SER_WAIT_MS    = 5;
  localparam int unsigned SER_WAIT_CYC   = SER_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAIT_W         = 21;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_PRI_EN    = 1'h1;
  localparam logic RST_PRI_PS    = 1'h1;
  localparam logic RST_SEC_PS    = 1'h1;
  localparam logic RST_KEEPALIVE = 1'h0;
  localparam logic RST_GPIO_DIR  = 1'h0;
  localparam logic RST_GPIO_PD   = 1'h1;
  localparam int unsigned GPIO_N = 3;

  // ****************************************
  // Power modes
  // ****************************************
  typedef enum logic [1:0] {
    PMS_OFF     = 2'b00,
    PMS_WAIT    = 2'b01,
    PMS_RUN     = 2'b10,
    PMS_PRI_OFF = 2'b11
  } pms_mode_t;

endpackage

// ### common/pms_sync_if.sv
`timescale 1ns/100ps
interface pms_sync_if;
  logic reg_ctl;
  logic clr_n;
  logic sel;
  modport src (output reg_ctl, output clr_n, output sel);
  modport dst (input reg_ctl, input clr_n, input sel);
endinterface

// ### rtl/pms_sync.sv
`timescale 1ns/100ps
module pms_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Raw pins
  input  wire logic regulator_control_pin,
  input  wire logic async_clear_n,
  input  wire logic host_port_select,
  // Filtered levels
  pms_sync_if.src   o
);

  // ****************************************
  // Three-stage synchronisers
  // ****************************************
  logic [2:0] s1_q, s2_q, s3_q, lvl_q;
  logic [2:0] s1_d, s2_d, s3_d, lvl_d;
  logic [2:0] raw;

  assign raw = {host_port_select, async_clear_n, regulator_control_pin};

  // A change is accepted once the second and third stages agree.
  always_comb begin
    s1_d  = raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < 3; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q  <= 3'h2;
      s2_q  <= 3'h2;
      s3_q  <= 3'h2;
      lvl_q <= 3'h2;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign o.reg_ctl = lvl_q[0];
  assign o.clr_n   = lvl_q[1];
  assign o.sel     = lvl_q[2];

endmodule

// ### rtl/pms_seq.sv
`timescale 1ns/100ps
module pms_seq #(
  // Serial hold-off length in clock cycles.
  parameter int unsigned WAIT_CYC = pms_pkg::SER_WAIT_CYC
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Control pins from the host
  input  wire logic                          regulator_control_pin,
  input  wire logic                          async_clear_n,
  input  wire logic                          host_port_select,
  // Decoded serial register writes
  input  wire logic                          wr_stb,
  input  wire logic                          wr_primary_regulator_enable,
  input  wire logic                          wr_primary_regulator_powersave,
  input  wire logic                          wr_secondary_regulator_powersave,
  input  wire logic                          wr_secondary_regulator_keep_alive,
  input  wire logic [pms_pkg::GPIO_N-1:0]    wr_gpio_dir,
  input  wire logic [pms_pkg::GPIO_N-1:0]    wr_gpio_pd,
  // Regulator controls
  output logic                               primary_regulator_on,
  output logic                               primary_regulator_ps,
  output logic                               secondary_regulator_on,
  output logic                               secondary_regulator_ps,
  // Control bit readback
  output logic                               primary_regulator_enable,
  output logic                               secondary_regulator_keep_alive,
  // Serial port gating and mode
  output logic                               serial_accept,
  output logic                               spi_mode,
  output pms_pkg::pms_mode_t                 mode,
  // General I/O configuration
  output logic [pms_pkg::GPIO_N-1:0]         gpio_dir,
  output logic [pms_pkg::GPIO_N-1:0]         gpio_pd
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pms_sync_if sy ();

  // Control, clear and select pins qualified by agreeing stages.
  pms_sync u_sync (
    .mclk                  (mclk),
    .rst                   (rst),
    .regulator_control_pin (regulator_control_pin),
    .async_clear_n         (async_clear_n),
    .host_port_select      (host_port_select),
    .o                     (sy.src)
  );

  // ****************************************
  // State
  // ****************************************
  pms_pkg::pms_mode_t           mode_q, mode_d;
  logic [pms_pkg::WAIT_W-1:0]   wait_q, wait_d;
  logic                         pen_q, pen_d;
  logic                         pps_q, pps_d;
  logic                         sps_q, sps_d;
  logic                         keep_q, keep_d;
  logic [pms_pkg::GPIO_N-1:0]   dir_q, dir_d;
  logic [pms_pkg::GPIO_N-1:0]   pd_q, pd_d;
  logic                         acc_q, acc_d;
  logic                         spi_q, spi_d;
  logic                         p_on_q, p_on_d;
  logic                         s_on_q, s_on_d;
  logic                         p_ps_q, p_ps_d;
  logic                         s_ps_q, s_ps_d;
  logic                         ctl_prev_q;
  logic                         ctl_rise;
  logic                         wr_ok;

  assign ctl_rise = sy.reg_ctl && !ctl_prev_q;
  // No writes while control pin low.
  // No writes while clear pin low.
  assign wr_ok = wr_stb && acc_q && sy.reg_ctl && sy.clr_n;

  always_comb begin
    mode_d = mode_q;
    wait_d = wait_q;
    pen_d  = pen_q;
    pps_d  = pps_q;
    sps_d  = sps_q;
    keep_d = keep_q;
    dir_d  = dir_q;
    pd_d   = pd_q;
    case (mode_q)
      pms_pkg::PMS_OFF, pms_pkg::PMS_PRI_OFF: begin
        if (ctl_rise) begin
          mode_d = pms_pkg::PMS_WAIT;
          wait_d = '0;
          pen_d  = pms_pkg::RST_PRI_EN;
          pps_d  = pms_pkg::RST_PRI_PS;
          sps_d  = pms_pkg::RST_SEC_PS;
          keep_d = pms_pkg::RST_KEEPALIVE;
          dir_d  = {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_DIR}};
          pd_d   = {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_PD}};
        end
      end
      pms_pkg::PMS_WAIT: begin
        // Hold off serial for 5 ms.
        if (wait_q == pms_pkg::WAIT_W'(WAIT_CYC - 1)) begin
          mode_d = pms_pkg::PMS_RUN;
        end else begin
          wait_d = wait_q + 1'b1;
        end
      end
      default: begin
        if (wr_ok) begin
          pen_d  = wr_primary_regulator_enable;
          pps_d  = wr_primary_regulator_powersave;
          sps_d  = wr_secondary_regulator_powersave;
          keep_d = wr_secondary_regulator_keep_alive;
          dir_d  = wr_gpio_dir;
          pd_d   = wr_gpio_pd;
        end
      end
    endcase
    // OFF keeps its four control bits cleared even while the clear pin is low.
    if (!sy.clr_n && mode_q != pms_pkg::PMS_OFF) begin
      pen_d  = pms_pkg::RST_PRI_EN;
      pps_d  = pms_pkg::RST_PRI_PS;
      sps_d  = pms_pkg::RST_SEC_PS;
      keep_d = pms_pkg::RST_KEEPALIVE;
      dir_d  = {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_DIR}};
      pd_d   = {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_PD}};
    end
    if (!sy.reg_ctl && mode_q != pms_pkg::PMS_OFF && mode_q != pms_pkg::PMS_PRI_OFF) begin
      if (keep_q && sy.clr_n) begin
        mode_d = pms_pkg::PMS_PRI_OFF;
        pen_d  = 1'b0;
      end else begin
        mode_d = pms_pkg::PMS_OFF;
        pen_d  = 1'b0;
        pps_d  = 1'b0;
        sps_d  = 1'b0;
        keep_d = 1'b0;
      end
    end
    if (!sy.clr_n && mode_q == pms_pkg::PMS_PRI_OFF) begin
      mode_d = pms_pkg::PMS_OFF;
      pen_d  = 1'b0;
      pps_d  = 1'b0;
      sps_d  = 1'b0;
      keep_d = 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    acc_d  = (mode_d == pms_pkg::PMS_RUN) && sy.clr_n;
    spi_d  = sy.sel;
    p_on_d = (mode_d == pms_pkg::PMS_RUN || mode_d == pms_pkg::PMS_WAIT) && pen_d;
    p_ps_d = pps_d;
    s_on_d = (mode_d != pms_pkg::PMS_OFF);
    s_ps_d = sps_d;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q     <= pms_pkg::PMS_OFF;
      wait_q     <= '0;
      pen_q      <= 1'b0;
      pps_q      <= 1'b0;
      sps_q      <= 1'b0;
      keep_q     <= 1'b0;
      dir_q      <= {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_DIR}};
      pd_q       <= {pms_pkg::GPIO_N{pms_pkg::RST_GPIO_PD}};
      acc_q      <= 1'b0;
      spi_q      <= 1'b0;
      p_on_q     <= 1'b0;
      s_on_q     <= 1'b0;
      p_ps_q     <= 1'b0;
      s_ps_q     <= 1'b0;
      ctl_prev_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      wait_q     <= wait_d;
      pen_q      <= pen_d;
      pps_q      <= pps_d;
      sps_q      <= sps_d;
      keep_q     <= keep_d;
      dir_q      <= dir_d;
      pd_q       <= pd_d;
      acc_q      <= acc_d;
      spi_q      <= spi_d;
      p_on_q     <= p_on_d;
      s_on_q     <= s_on_d;
      p_ps_q     <= p_ps_d;
      s_ps_q     <= s_ps_d;
      ctl_prev_q <= sy.reg_ctl;
    end
  end

  assign primary_regulator_on           = p_on_q;
  assign primary_regulator_ps           = p_ps_q;
  assign secondary_regulator_on         = s_on_q;
  assign secondary_regulator_ps         = s_ps_q;
  assign primary_regulator_enable       = pen_q;
  assign secondary_regulator_keep_alive = keep_q;
  assign serial_accept                  = acc_q;
  assign spi_mode                       = spi_q;
  assign mode                           = mode_q;
  assign gpio_dir                       = dir_q;
  assign gpio_pd                        = pd_q;

endmodule

// ### verif/pms_seq_monitor.sv
`timescale 1ns/100ps
module pms_seq_monitor (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Decoded writes
  input wire logic               wr_stb,
  input wire logic               wr_primary_regulator_enable,
  input wire logic               wr_secondary_regulator_powersave,
  // Regulator and status outputs
  input wire logic               primary_regulator_on,
  input wire logic               primary_regulator_ps,
  input wire logic               secondary_regulator_on,
  input wire logic               secondary_regulator_ps,
  input wire logic               primary_regulator_enable,
  input wire logic               serial_accept,
  input wire pms_pkg::pms_mode_t mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ****************
  // Properties
  // ****************
  property p_off_shut;
    mode == pms_pkg::PMS_OFF |-> !serial_accept;
  endproperty
  property p_wait_shut;
    mode == pms_pkg::PMS_WAIT |-> !serial_accept;
  endproperty
  property p_wait_ps;
    mode == pms_pkg::PMS_WAIT && $past(mode) == pms_pkg::PMS_WAIT
      |-> primary_regulator_on && primary_regulator_ps && secondary_regulator_ps;
  endproperty
  property p_off_bits;
    mode == pms_pkg::PMS_OFF && $past(mode) == pms_pkg::PMS_OFF |-> !(primary_regulator_on
      || primary_regulator_ps || secondary_regulator_on || secondary_regulator_ps);
  endproperty
  property p_sec_run;
    mode == pms_pkg::PMS_RUN && $past(mode) == pms_pkg::PMS_RUN |-> secondary_regulator_on;
  endproperty
  property p_pri_off;
    mode == pms_pkg::PMS_PRI_OFF && $past(mode) == pms_pkg::PMS_PRI_OFF
      |-> secondary_regulator_on && !primary_regulator_on;
  endproperty
  property p_wr_en;
    wr_stb && serial_accept |=> primary_regulator_enable == $past(wr_primary_regulator_enable);
  endproperty
  property p_wr_ps;
    wr_stb && serial_accept
      |-> ##2 secondary_regulator_ps == $past(wr_secondary_regulator_powersave, 2);
  endproperty

  // ****************
  // Checks
  // ****************
  a_off_shut: assert property (p_off_shut) else $error("port open in off");
  a_wait_shut: assert property (p_wait_shut) else $error("port open in wait");
  a_wait_ps: assert property (p_wait_ps) else $error("wake not power save");
  a_off_bits: assert property (p_off_bits) else $error("off bits set");
  a_sec_run: assert property (p_sec_run) else $error("secondary off");
  a_pri_off: assert property (p_pri_off) else $error("primary only off bad");
  a_wr_en: assert property (p_wr_en) else $error("enable not written");
  a_wr_ps: assert property (p_wr_ps) else $error("power save not written");
  c_pri_off: cover property (mode == pms_pkg::PMS_PRI_OFF);
  c_write: cover property (wr_stb && serial_accept);
  c_wait: cover property (mode == pms_pkg::PMS_WAIT);
endmodule

bind pms_seq pms_seq_monitor u_mon (
  .mclk, .rst, .wr_stb, .wr_primary_regulator_enable, .wr_secondary_regulator_powersave,
  .primary_regulator_on, .primary_regulator_ps, .secondary_regulator_on,
  .secondary_regulator_ps, .primary_regulator_enable, .serial_accept, .mode
);

// ### verif/pms_host_model.sv
`timescale 1ns/100ps
module pms_host_model (
  // Clock
  input wire logic   mclk,
  // Pins and decoded writes
  output logic       ctl,
  output logic       clr_n,
  output logic       sel,
  output logic       stb,
  output logic [9:0] d
);
  initial begin
    ctl = 1'h0;
    clr_n = 1'h1;
    sel = 1'h0;
    stb = 1'h0;
    d = 10'h000;
  end

  task automatic pins(input logic c, input logic n);
    @(posedge mclk);
    #1;
    ctl = c;
    clr_n = n;
    sel = 1'h1;
    repeat (10) @(posedge mclk);
  endtask

  // Released data shows the inverse so stale values cannot pass.
  task automatic write(input logic [9:0] v);
    @(posedge mclk);
    #1;
    d = v;
    stb = 1'h1;
    @(posedge mclk);
    #1;
    stb = 1'h0;
    d = ~v;
  endtask
endmodule

// ### verif/power_mode_sequencer_test.sv
`timescale 1ns/100ps
module power_mode_sequencer_test;
  localparam int unsigned SIM_WAIT = 1000;
  localparam int LIMIT = 4 * SIM_WAIT + 1000;
  logic               mclk;
  logic               rst;
  logic               ctl, clr_n, sel, stb;
  logic [9:0]         d;
  logic               pon, pps, son, sps, pen, keep, acc, spi;
  logic [2:0]         dir, pd;
  pms_pkg::pms_mode_t mode;
  int                 fails, n_tests, cyc, n;

  pms_host_model host (.mclk, .ctl, .clr_n, .sel, .stb, .d);

  pms_seq #(.WAIT_CYC(SIM_WAIT)) dut (
    .mclk, .rst, .regulator_control_pin(ctl), .async_clear_n(clr_n), .host_port_select(sel),
    .wr_stb(stb), .wr_primary_regulator_enable(d[9]), .wr_primary_regulator_powersave(d[8]),
    .wr_secondary_regulator_powersave(d[7]), .wr_secondary_regulator_keep_alive(d[6]),
    .wr_gpio_dir(d[5:3]), .wr_gpio_pd(d[2:0]), .primary_regulator_on(pon),
    .primary_regulator_ps(pps), .secondary_regulator_on(son), .secondary_regulator_ps(sps),
    .primary_regulator_enable(pen), .secondary_regulator_keep_alive(keep),
    .serial_accept(acc), .spi_mode(spi), .mode, .gpio_dir(dir), .gpio_pd(pd)
  );

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    step(12);
    rst = 1'h0;
    check("reset", {mode, pon, pps, son, sps, pen, keep, acc, spi}, 10'h000);
    check("gpio", {dir, pd}, 6'h07);
    host.write(10'h3FF);
    step(4);
    check("locked", {mode, pen, keep, acc, dir}, 8'h00);
    host.pins(1'h1, 1'h1);
    step(1);
    check("spi", spi, 1'h1);
    check("wake", {mode, pon, pps, son, sps, pen, acc}, 8'h7E);
    n = 0;
    while (acc !== 1'h1) begin
      step(1);
      n++;
    end
    check("delay", {n > SIM_WAIT - 20, n < SIM_WAIT + 4}, 2'h3);
    check("run", mode, pms_pkg::PMS_RUN);
    for (int i = 0; i < 8; i++) begin
      host.write({i[2:0], 1'h0, i[2:0], ~i[2:0]});
      step(3);
      check("write", {pon, pps, sps, son, pen, dir, pd}, {i[2:0], 1'h1, i[2], i[2:0], ~i[2:0]});
    end
    host.write(10'h3C7);
    step(3);
    check("keep", keep, 1'h1);
    host.pins(1'h0, 1'h1);
    step(1);
    check("pri_off", {mode, pon, son}, 4'hD);
    host.pins(1'h1, 1'h1);
    step(1);
    check("rewake", {mode != pms_pkg::PMS_OFF, mode != pms_pkg::PMS_PRI_OFF, son}, 3'h7);
    while (acc !== 1'h1) begin
      step(1);
    end
    host.write(10'h038);
    step(3);
    check("pre_clear", {pen, pps, sps, dir, pd}, 9'h038);
    host.pins(1'h1, 1'h0);
    host.write(10'h000);
    step(3);
    check("clear", {pen, keep, acc, pps, sps, dir, pd}, 11'h4C7);
    host.pins(1'h0, 1'h0);
    step(1);
    check("off", {mode, pon, pps, son, sps, pen, keep}, 8'h00);
    host.pins(1'h1, 1'h1);
    while (acc !== 1'h1) begin
      step(1);
    end
    host.pins(1'h0, 1'h1);
    step(1);
    check("ctl_first", {mode, pon, pps, son, sps, pen, keep}, 8'h00);
    end_of_test();
  end
endmodule
